/* File: rtl/tmw_pkg.sv */
// Package for the timer prescaler and waveform block.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package tmw_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_WAVE_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_WAVE_CTRL_B = 8'h04;
    localparam logic [7:0] OFS_ASYNC_STAT  = 8'h08;
    localparam logic [7:0] OFS_GEN_CTRL    = 8'h0c;
    localparam logic [7:0] OFS_COUNT       = 8'h10;
    localparam logic [7:0] OFS_CMP_A       = 8'h14;
    localparam logic [7:0] OFS_CMP_B       = 8'h18;
    localparam logic [7:0] OFS_FLAGS       = 8'h1c;
    // Field positions
    localparam int COM_A_HI = 7;
    localparam int COM_A_LO = 6;
    localparam int COM_B_HI = 5;
    localparam int COM_B_LO = 4;
    localparam int WGM_HI_BIT = 3;      // In control B
    localparam int ASYNC_BIT = 5;       // In async status
    localparam int PSR_BIT = 1;         // In general control
    localparam int FLAG_OVF = 0;
    localparam int FLAG_CMPA = 1;
    localparam int FLAG_CMPB = 2;
    // Masks of readable bits
    localparam logic [7:0] CTRL_A_MASK = 8'hf3;
    localparam logic [7:0] CTRL_B_MASK = 8'h0f;
    // Counter landmarks
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX    = 8'hff;
    localparam logic [7:0] RST_BYTE   = 8'h00;
    // Prescaler taps
    localparam int PSC_W = 10;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV32 = 3'h3;
    localparam logic [2:0] CS_DIV64 = 3'h4;
    localparam logic [2:0] CS_DIV128 = 3'h5;
    localparam logic [2:0] CS_DIV256 = 3'h6;
    localparam logic [2:0] CS_DIV1024 = 3'h7;
    // Waveform modes
    localparam logic [2:0] WM_NORMAL  = 3'h0;
    localparam logic [2:0] WM_PC_FF   = 3'h1;
    localparam logic [2:0] WM_CTC     = 3'h2;
    localparam logic [2:0] WM_FAST_FF = 3'h3;
    localparam logic [2:0] WM_PC_A    = 3'h5;
    localparam logic [2:0] WM_FAST_A  = 3'h7;
    // Compare output modes
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TGL = 2'h1;
    localparam logic [1:0] COM_CLR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;

    typedef struct packed {
        logic drive;
        logic level;
        logic enable;
    } tmw_pin_s;
endpackage : tmw_pkg

/* File: rtl/tmw_timer.sv */
// Timer clock source, prescaler, counter and two compare waveform outputs.
// Assumes an APB master on clk_sys; the oscillator pin is a level synchronous to clk_sys.
// Functional notes
// R1: Source clock is system clock, or oscillator pin when async select set.
// R2: Async select detaches both oscillator pins from port function.
// R3: Prescaler offers stop, undivided, and divide by 8..1024.
// R4: Clock select 000 stop, 001 undivided, 010..111 divide 8..1024.
// R5: Writing one to prescaler reset clears the division counter.
// R6: Channel A mode bits 7:6; nonzero overrides port function.
// R7: Compare output drives pin only when direction bit set.
// R8: Non-PWM modes: 00 off, 01 toggle, 10 clear, 11 set on match.
// R9: Fast PWM: 10 clear on match set at bottom, 11 inverse.
// R10: Channel A PWM mode 01 toggles only when waveform high bit set.
// R11: Fast PWM compare equal TOP with upper bit: act at bottom.
// R12: Phase correct: 10 clears up-counting, sets down-counting; 11 reverse.
// R13: Phase correct compare equal TOP with upper bit: act at TOP.
// R14: Channel B mode bits 5:4, same encodings as channel A.
// R15: Software avoids channel B mode 01 in PWM modes.
// R16: Control A bits 3:2 read as zero.
// R17: Bits 1:0 plus waveform high bit form three-bit mode.
// R18: Normal and clear-on-match update compares immediately, overflow at MAX.
// R19: Phase correct modes load compares at TOP, overflow at bottom.
// R20: Fast PWM modes load at bottom; overflow MAX or TOP.
// R21: Software avoids reserved waveform modes 4 and 6.
// R22: Bottom is 0x00, MAX is 0xff.
// R23: Stopped clock: counter frozen, no compare or overflow events.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module tmw_timer
    import tmw_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        osc_in_pin,
    input  wire logic        dir_a,
    input  wire logic        dir_b,
    output logic             osc_pins_detach,
    output tmw_pin_s         compare_out_a,
    output tmw_pin_s         compare_out_b
);
    // Registers
    logic [7:0]     timer_wave_control_a;
    logic [7:0]     timer_wave_control_b;
    logic           async_clock_select;
    logic [7:0]     count;
    logic [7:0]     compare_value_a;
    logic [7:0]     compare_value_b;
    logic [7:0]     buf_a;
    logic [7:0]     buf_b;
    logic [2:0]     flags;
    logic           count_down;
    logic           out_a;
    logic           out_b;
    logic [PSC_W-1:0] psc;
    logic           osc_prev;
    logic           src_tick;
    logic           tick;
    logic [2:0]     waveform_mode;
    logic [2:0]     clock_select_field;
    logic [1:0]     compare_out_mode_a;
    logic [1:0]     compare_out_mode_b;
    logic [7:0]     top;
    logic           is_fast;
    logic           is_pc;
    logic           wr;
    logic           rd;
    logic           hit_a;
    logic           hit_b;
    logic           at_top;
    logic           at_bottom;
    logic           ovf_ev;
    logic [7:0]     next_count;
    logic           next_down;

    assign compare_out_mode_a = timer_wave_control_a[COM_A_HI:COM_A_LO]; // R6
    assign compare_out_mode_b = timer_wave_control_a[COM_B_HI:COM_B_LO]; // R14
    assign waveform_mode = {timer_wave_control_b[WGM_HI_BIT], timer_wave_control_a[1:0]}; // R17
    assign clock_select_field = timer_wave_control_b[2:0];
    assign is_fast = (waveform_mode == WM_FAST_FF) || (waveform_mode == WM_FAST_A);
    assign is_pc = (waveform_mode == WM_PC_FF) || (waveform_mode == WM_PC_A);
    assign top = (waveform_mode == WM_CTC || waveform_mode == WM_PC_A
                  || waveform_mode == WM_FAST_A) ? compare_value_a : CNT_MAX;
    assign osc_pins_detach = async_clock_select; // R2

    // APB: zero-wait slave, unmapped reads give zero with an error
    assign wr = psel && penable && pwrite && clk_en;
    assign rd = psel && !pwrite;
    assign pready = 1'b1;
    always_comb begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        unique case (paddr)
            OFS_WAVE_CTRL_A: prdata[7:0] = timer_wave_control_a & CTRL_A_MASK; // R16
            OFS_WAVE_CTRL_B: prdata[7:0] = timer_wave_control_b & CTRL_B_MASK;
            OFS_ASYNC_STAT:  prdata[ASYNC_BIT] = async_clock_select;
            OFS_GEN_CTRL:    prdata = 32'h0000_0000; // Reset bit self-clears
            OFS_COUNT:       prdata[7:0] = count;
            OFS_CMP_A:       prdata[7:0] = compare_value_a;
            OFS_CMP_B:       prdata[7:0] = compare_value_b;
            OFS_FLAGS:       prdata[2:0] = flags;
            default:         pslverr = psel && penable && (rd || pwrite);
        endcase
    end

    // Control registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timer_wave_control_a <= RST_BYTE;
            timer_wave_control_b <= RST_BYTE;
            async_clock_select   <= 1'b0;
        end else if (wr) begin
            if (paddr == OFS_WAVE_CTRL_A) timer_wave_control_a <= pwdata[7:0] & CTRL_A_MASK;
            if (paddr == OFS_WAVE_CTRL_B) timer_wave_control_b <= pwdata[7:0] & CTRL_B_MASK;
            if (paddr == OFS_ASYNC_STAT) async_clock_select <= pwdata[ASYNC_BIT];
        end
    end

    // Source tick: every system cycle, or a rising oscillator edge
    always_ff @(posedge clk_sys) begin
        if (rst) osc_prev <= 1'b0;
        else if (clk_en) osc_prev <= osc_in_pin;
    end
    assign src_tick = async_clock_select ? (osc_in_pin && !osc_prev) : 1'b1; // R1

    // Prescaler; free-running on the source, cleared by software
    always_ff @(posedge clk_sys) begin
        if (rst) psc <= '0;
        else if (clk_en) begin
            if (wr && paddr == OFS_GEN_CTRL && pwdata[PSR_BIT]) psc <= '0; // R5
            else if (src_tick) psc <= psc + 1'b1;
        end
    end

    // Tap decoding: tick when the low bits of the next count wrap
    function automatic logic tap(input logic [PSC_W-1:0] p, input int bits);
        logic [PSC_W-1:0] m;
        m = PSC_W'((1 << bits) - 1);
        return (p & m) == m;
    endfunction : tap

    always_comb begin
        unique case (clock_select_field) // R3 R4
            CS_STOP:    tick = 1'b0; // R23
            CS_DIV1:    tick = src_tick;
            CS_DIV8:    tick = src_tick && tap(psc, 3);
            CS_DIV32:   tick = src_tick && tap(psc, 5);
            CS_DIV64:   tick = src_tick && tap(psc, 6);
            CS_DIV128:  tick = src_tick && tap(psc, 7);
            CS_DIV256:  tick = src_tick && tap(psc, 8);
            CS_DIV1024: tick = src_tick && tap(psc, 10);
        endcase
    end

    // Match and landmark decoding, qualified by the timer tick
    assign hit_a = tick && (count == compare_value_a);
    assign hit_b = tick && (count == compare_value_b);
    assign at_top = tick && (count == top);
    assign at_bottom = tick && (count == CNT_BOTTOM); // R22
    always_comb begin
        unique case (waveform_mode)
            WM_PC_FF, WM_PC_A: ovf_ev = at_bottom && count_down; // R19
            WM_FAST_A:         ovf_ev = at_top; // R20
            default:           ovf_ev = tick && (count == CNT_MAX); // R18 R22
        endcase
    end

    // Counter sequence per mode
    always_comb begin
        next_count = count;
        next_down  = count_down;
        if (is_pc) begin
            if (!count_down) begin
                if (count == top) begin
                    next_down  = 1'b1;
                    next_count = count - 1'b1;
                end else next_count = count + 1'b1;
            end else begin
                if (count == CNT_BOTTOM) begin
                    next_down  = 1'b0;
                    next_count = count + 1'b1;
                end else next_count = count - 1'b1;
            end
        end else begin
            next_down  = 1'b0;
            next_count = (count == top && waveform_mode != WM_NORMAL) ? CNT_BOTTOM
                                                                      : count + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count      <= RST_BYTE;
            count_down <= 1'b0;
        end else if (clk_en) begin
            if (wr && paddr == OFS_COUNT) count <= pwdata[7:0];
            else if (tick) begin // R23
                count      <= next_count;
                count_down <= next_down;
            end
        end
    end

    // Compare buffers and their load point
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            buf_a <= RST_BYTE;
            buf_b <= RST_BYTE;
            compare_value_a <= RST_BYTE;
            compare_value_b <= RST_BYTE;
        end else if (clk_en) begin
            if (wr && paddr == OFS_CMP_A) buf_a <= pwdata[7:0];
            if (wr && paddr == OFS_CMP_B) buf_b <= pwdata[7:0];
            if (!is_fast && !is_pc) begin
                // Immediate update avoids a stale buffer in plain modes
                compare_value_a <= (wr && paddr == OFS_CMP_A) ? pwdata[7:0] : buf_a; // R18
                compare_value_b <= (wr && paddr == OFS_CMP_B) ? pwdata[7:0] : buf_b;
            end else if ((is_pc && at_top && !count_down) || (is_fast && at_top)) begin
                compare_value_a <= buf_a; // R19 R20
                compare_value_b <= buf_b;
            end
        end
    end

    // Event flags, write one to clear; a set in the same cycle wins
    always_ff @(posedge clk_sys) begin
        if (rst) flags <= 3'h0;
        else if (clk_en) begin
            flags <= (flags & ~((wr && paddr == OFS_FLAGS) ? pwdata[2:0] : 3'h0))
                     | {hit_b, hit_a, ovf_ev};
        end
    end

    // Next output level for one channel
    function automatic logic wave_next(input logic cur, input logic [1:0] mode,
                                       input logic hit, input logic eq_top,
                                       input logic chan_a);
        logic r;
        r = cur;
        if (is_fast) begin
            if (mode == COM_TGL) begin
                if (chan_a && timer_wave_control_b[WGM_HI_BIT] && hit) r = !cur; // R10
            end else if (mode[1]) begin
                if (hit && !eq_top) r = (mode == COM_SET); // R9 R11
                if (at_top && waveform_mode == WM_FAST_FF && count == CNT_MAX
                    || at_top && waveform_mode == WM_FAST_A)
                    r = (mode == COM_CLR) ? 1'b1 : 1'b0;
                if (hit && eq_top) r = (mode == COM_CLR) ? 1'b1 : 1'b0; // R11
            end
        end else if (is_pc) begin
            if (mode == COM_TGL) begin
                if (chan_a && timer_wave_control_b[WGM_HI_BIT] && hit) r = !cur; // R10
            end else if (mode[1] && hit) begin
                if (eq_top) r = (mode == COM_CLR) ? 1'b0 : 1'b1; // R13
                else r = (mode == COM_CLR) ? count_down : !count_down; // R12
            end
        end else if (hit) begin
            unique case (mode) // R8
                COM_TGL: r = !cur;
                COM_CLR: r = 1'b0;
                COM_SET: r = 1'b1;
                default: r = cur;
            endcase
        end
        return r;
    endfunction : wave_next

    // Waveform registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            out_a <= 1'b0;
            out_b <= 1'b0;
        end else if (clk_en) begin
            out_a <= wave_next(out_a, compare_out_mode_a, hit_a, compare_value_a == top, 1'b1);
            out_b <= wave_next(out_b, compare_out_mode_b, hit_b, compare_value_b == top, 1'b0);
        end
    end

    // Pin override; driver enabled only with the direction bit
    assign compare_out_a.level  = out_a;
    assign compare_out_a.drive  = compare_out_mode_a != COM_OFF; // R6
    assign compare_out_a.enable = (compare_out_mode_a != COM_OFF) && dir_a; // R7
    assign compare_out_b.level  = out_b;
    assign compare_out_b.drive  = compare_out_mode_b != COM_OFF; // R14
    assign compare_out_b.enable = (compare_out_mode_b != COM_OFF) && dir_b; // R7
endmodule : tmw_timer

/* File: test/tmw_timer_checker.sv */
// Port-level assertions for the timer waveform block.
// Assumes a bind from the bench top; one clock domain, sync reset.
`timescale 1ns/1ps
module tmw_timer_checker
    import tmw_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        osc_in_pin,
    input wire logic        dir_a,
    input wire logic        dir_b,
    input wire logic        osc_pins_detach,
    input wire tmw_pin_s    compare_out_a,
    input wire tmw_pin_s    compare_out_b
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Accepted writes need clk_en; reads do not
    wire logic wr_go = psel && penable && pwrite && clk_en;
    wire logic rd_go = psel && penable && !pwrite;

    property p_detach;
        wr_go && paddr == OFS_ASYNC_STAT |=> osc_pins_detach == $past(pwdata[ASYNC_BIT]);
    endproperty
    a_detach: assert property (p_detach) else $error("detach not following select");
    property p_en_a;
        compare_out_a.enable == (compare_out_a.drive && dir_a);
    endproperty
    a_en_a: assert property (p_en_a) else $error("driver A enable wrong");
    property p_en_b;
        compare_out_b.enable == (compare_out_b.drive && dir_b);
    endproperty
    a_en_b: assert property (p_en_b) else $error("driver B enable wrong");
    property p_ovr_a;
        wr_go && paddr == OFS_WAVE_CTRL_A
            |=> compare_out_a.drive == ($past(pwdata[COM_A_HI]) || $past(pwdata[COM_A_LO]));
    endproperty
    a_ovr_a: assert property (p_ovr_a) else $error("override A wrong");
    property p_ovr_b;
        wr_go && paddr == OFS_WAVE_CTRL_A
            |=> compare_out_b.drive == ($past(pwdata[COM_B_HI]) || $past(pwdata[COM_B_LO]));
    endproperty
    a_ovr_b: assert property (p_ovr_b) else $error("override B wrong");
    property p_rsv;
        rd_go && paddr == OFS_WAVE_CTRL_A |-> prdata[3:2] == 2'h0 && prdata[31:8] == 24'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
    property p_ctl_b;
        rd_go && paddr == OFS_WAVE_CTRL_B |-> prdata[31:4] == 28'h0;
    endproperty
    a_ctl_b: assert property (p_ctl_b) else $error("control B upper bits set");
    property p_psr;
        rd_go && paddr == OFS_GEN_CTRL |-> prdata == 32'h0;
    endproperty
    a_psr: assert property (p_psr) else $error("prescaler reset reads nonzero");
    property p_gate;
        !clk_en |=> $stable(compare_out_a.level) && $stable(compare_out_b.level);
    endproperty
    a_gate: assert property (p_gate) else $error("output moved while frozen");

    c_rise: cover property (compare_out_a.enable && $rose(compare_out_a.level));
    c_err: cover property (pslverr);
    c_drop: cover property (psel && penable && pwrite && !clk_en);
endmodule : tmw_timer_checker

/* File: test/tmw_timer_tb.sv */
// Self-checking bench for the timer waveform block.
// Assumes tmw_timer with zero-wait APB at the package offsets.
`timescale 1ns/1ps
module tmw_timer_tb
    import tmw_pkg::*;
;
    logic        clk_sys, rst, clk_en, psel, penable, pwrite, pready, pslverr, ev;
    logic        osc_in_pin = 1'b0, dir_a, dir_b, osc_pins_detach;
    logic [1:0]  q = 2'h0, lv, m;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rv, c0;
    tmw_pin_s    compare_out_a, compare_out_b;
    int          fail_count, samples_checked, n, ca, cb;
    int          seed = 32'hd97e3a5c;
    int          dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};

    tmw_timer tmw_timer_inst (.clk_sys, .rst, .clk_en, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .osc_in_pin, .dir_a, .dir_b, .osc_pins_detach,
        .compare_out_a, .compare_out_b);

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Oscillator pin rises every fourth cycle, so async spans stay exact
    always @(posedge clk_sys) begin
        q <= q + 2'h1;
        osc_in_pin <= q[1];
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        lv = {compare_out_b.level, compare_out_a.level};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic print_verdict;
        $display("mismatches %0d, comparisons %0d", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    // Skip samples where the edge position is not pinned down
    function automatic bit far(int v, int c);
        return v > 2 && v < 253 && (v > c + 2 || v + 2 < c);
    endfunction : far

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {rst, clk_en, dir_a, dir_b} = 4'hf;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        // Reset values, then one unmapped word
        for (n = 0; n <= 32'h20; n += 4) begin
            apb(1'b0, n[7:0], 32'h0);
            chk(rv, 32'h0);
            chk(32'(ev), 32'(n == 32'h20));
        end
        n = $random(seed);
        apb(1'b1, OFS_WAVE_CTRL_A, n);
        apb(1'b0, OFS_WAVE_CTRL_A, 32'h0);
        chk(rv, n & 32'hf3);
        c0 = rv;
        n = $random(seed) & 32'h07;
        apb(1'b1, OFS_WAVE_CTRL_B, n);
        apb(1'b0, OFS_WAVE_CTRL_B, 32'h0);
        chk(rv, n);
        // Write while frozen must be dropped
        clk_en <= 1'b0;
        apb(1'b1, OFS_WAVE_CTRL_A, ~c0);
        clk_en <= 1'b1;
        apb(1'b0, OFS_WAVE_CTRL_A, 32'h0);
        chk(rv, c0);
        // Ticks over a span of exactly three divided periods
        apb(1'b1, OFS_WAVE_CTRL_A, 32'h0);
        for (n = 0; n < 8; n++) begin
            apb(1'b1, OFS_WAVE_CTRL_B, n);
            apb(1'b0, OFS_COUNT, 32'h0);
            c0 = rv;
            repeat (3 * (n == 0 ? 8 : dv[n]) - 3) @(posedge clk_sys);
            apb(1'b0, OFS_COUNT, 32'h0);
            chk((rv - c0) & 32'hff, n == 0 ? 0 : 3);
        end
        // Undivided, so every oscillator rise is one count
        apb(1'b1, OFS_WAVE_CTRL_B, 32'h1);
        apb(1'b1, OFS_ASYNC_STAT, 32'h20);
        apb(1'b0, OFS_COUNT, 32'h0);
        c0 = rv;
        repeat (9) @(posedge clk_sys);
        apb(1'b0, OFS_COUNT, 32'h0);
        chk((rv - c0) & 32'hff, 32'h3);
        chk(32'(osc_pins_detach), 32'h1);
        apb(1'b1, OFS_ASYNC_STAT, 32'h0);
        // Prescaler reset holds off the first divide-by-1024 tick
        apb(1'b1, OFS_WAVE_CTRL_B, 32'h7);
        apb(1'b1, OFS_GEN_CTRL, 32'h2);
        apb(1'b1, OFS_COUNT, 32'h0);
        repeat (990) @(posedge clk_sys);
        apb(1'b0, OFS_COUNT, 32'h0);
        chk(rv, 32'h0);
        repeat (40) @(posedge clk_sys);
        apb(1'b0, OFS_COUNT, 32'h0);
        chk(rv, 32'h1);
        // Normal mode: set, clear, toggle, toggle across one match
        ca = 10 + ($random(seed) & 127);
        apb(1'b1, OFS_CMP_A, ca);
        apb(1'b1, OFS_CMP_B, ca);
        for (n = 0; n < 4; n++) begin
            m = n < 2 ? 2'(3 - n) : COM_TGL;
            apb(1'b1, OFS_WAVE_CTRL_B, 32'h0);
            apb(1'b1, OFS_COUNT, ca - 5);
            apb(1'b1, OFS_WAVE_CTRL_A, 32'({m, m, 4'h0}));
            apb(1'b1, OFS_WAVE_CTRL_B, 32'h1);
            repeat (60) @(posedge clk_sys);
            apb(1'b0, OFS_COUNT, 32'h0);
            chk(32'(lv), n[0] ? 32'h0 : 32'h3);
        end
        // Fast and phase correct PWM, both polarities
        for (n = 0; n < 4; n++) begin
            m = n[0] ? COM_SET : COM_CLR;
            ca = 20 + ($random(seed) & 32'hbf);
            cb = 20 + ($random(seed) & 32'hbf);
            dir_a <= $random(seed);
            dir_b <= $random(seed);
            apb(1'b1, OFS_CMP_A, ca);
            apb(1'b1, OFS_CMP_B, cb);
            apb(1'b1, OFS_WAVE_CTRL_A, 32'({m, m, 2'h0, n[1] ? 2'h1 : 2'h3}));
            apb(1'b1, OFS_WAVE_CTRL_B, 32'h1);
            repeat (600) @(posedge clk_sys);
            repeat (12) begin
                repeat ($random(seed) & 63) @(posedge clk_sys);
                apb(1'b0, OFS_COUNT, 32'h0);
                if (far(int'(rv), ca)) chk(32'(lv[0]), 32'((rv < ca) ^ n[0]));
                if (far(int'(rv), cb)) chk(32'(lv[1]), 32'((rv < cb) ^ n[0]));
            end
        end
        // Clear-on-match: count stays at or below compare A, no overflow once settled
        apb(1'b1, OFS_WAVE_CTRL_A, 32'({COM_OFF, COM_OFF, 2'h0, 2'h2}));
        repeat (300) @(posedge clk_sys);
        apb(1'b1, OFS_FLAGS, 32'h7);
        repeat (300) @(posedge clk_sys);
        apb(1'b0, OFS_FLAGS, 32'h0);
        chk(rv & 32'h3, 32'h2);
        repeat (4) begin
            repeat ($random(seed) & 63) @(posedge clk_sys);
            apb(1'b0, OFS_COUNT, 32'h0);
            chk(32'(rv <= ca), 32'h1);
        end
        print_verdict();
    end

    // Hang guard, well above the roughly 11000 cycles needed
    initial begin
        repeat (40000) @(posedge clk_sys);
        fail_count++;
        print_verdict();
    end
endmodule : tmw_timer_tb

bind tmw_timer tmw_timer_checker tmw_timer_checker_inst (.clk_sys, .rst, .clk_en, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .osc_in_pin, .dir_a,
    .dir_b, .osc_pins_detach, .compare_out_a, .compare_out_b);
